/* design/oscp_pkg.sv */
package oscp_pkg;
   // ----------------------------------------------------------------
   // register map (word index, byte address = 4 x index)
   // ----------------------------------------------------------------
   localparam logic [7:0] OUTCTL_IDX = 8'h29;
   localparam logic [7:0] OUTDIV_IDX = 8'h2a;
   localparam logic [9:0] OUTCTL_ADDR = {OUTCTL_IDX, 2'b00};
   localparam logic [9:0] OUTDIV_ADDR = {OUTDIV_IDX, 2'b00};
   localparam logic [7:0] OUTCTL_RST = 8'h18;
   localparam logic [7:0] OUTDIV_RST = 8'h05;
   // ----------------------------------------------------------------
   // field positions inside channel_six_output_control
   // ----------------------------------------------------------------
   localparam int SRC_LSB = 6;
   localparam int FMT_LSB = 4;
   localparam int MODE1_LSB = 2;
   localparam int MODE2_LSB = 0;
   localparam int FLD_W = 2;
   // ----------------------------------------------------------------
   // source and format codes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OSCP_SRC_SYN1 = 2'h0,
      OSCP_SRC_SYN2 = 2'h1,
      OSCP_SRC_PRI = 2'h2,
      OSCP_SRC_SEC = 2'h3
   } oscp_src_t;
   typedef enum logic [1:0] {
      OSCP_FMT_OFF = 2'h0,
      OSCP_FMT_ACDIFF = 2'h1,
      OSCP_FMT_HCSL = 2'h2,
      OSCP_FMT_CMOS = 2'h3
   } oscp_fmt_t;
   // single-ended pin modes and the HCSL load tri-state code
   localparam logic [1:0] PIN_OFF_TRI = 2'h0;
   localparam logic [1:0] PIN_OFF_LOW = 2'h1;
   localparam logic [1:0] PIN_ON_INV = 2'h2;
   localparam logic [1:0] PIN_ON_TRUE = 2'h3;
   localparam logic [1:0] HCSL_LOAD_TRI = 2'h0;
endpackage

/* design/oscp_divider.sv */
// channel divider: counts rising edges of the sampled source clock
module oscp_divider #(
   parameter int DIV_W = 8
) (
   input wire logic mclk_in, // system clock
   input wire logic sys_rst_in, // synchronous reset, high
   input wire logic clk_in, // sampled source clock level
   input wire logic [DIV_W-1:0] div_in, // ratio minus one
   input wire logic bypass_in, // pass source undivided
   output logic clk_out // divided clock level
);
   logic prev_q;
   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] half;
   logic rise;

   // next edge count, wrapping after the last edge of a period
   function automatic logic [DIV_W-1:0] next_cnt(input logic [DIV_W-1:0] cnt,
      input logic [DIV_W-1:0] lim);
      next_cnt = (cnt >= lim) ? '0 : cnt + DIV_W'(1);
   endfunction

   // ------------------------------------------------------------
   // edge detect and half-period threshold
   // ------------------------------------------------------------
   assign rise = clk_in & ~prev_q;
   assign half = DIV_W'((DIV_W+1)'(div_in) + (DIV_W+1)'(1) >> 1);

   // remember last source level
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         prev_q <= 1'b0;
      else
         prev_q <= clk_in;
   end

   // edge counter wraps after div_in + 1 edges
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in || bypass_in)
         cnt_q <= '0;
      else if (rise)
         cnt_q <= next_cnt(cnt_q, div_in);
   end

   // output: pass-through for ratio 1 or bypass, else high first half
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         clk_out <= 1'b0;
      else if (bypass_in || div_in == '0)
         clk_out <= clk_in;
      else if (rise)
         clk_out <= next_cnt(cnt_q, div_in) < half;
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_div_wrap;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (!sys_rst_in && rise && !bypass_in && cnt_q == div_in) |=> (cnt_q == '0);
   endproperty
   a_div_wrap: assert property (p_div_wrap)
      else $error("divider did not wrap after last edge");

   property p_div_pass;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (!sys_rst_in && (bypass_in || div_in == '0)) |=> (clk_out == $past(clk_in));
   endproperty
   a_div_pass: assert property (p_div_pass)
      else $error("undivided path does not follow source");
endmodule // oscp_divider

/* design/oscp_top.sv */
// Operation
// - source code 0..3 picks synth one, synth two, primary, secondary reference
// - with doubler active a reference source is delivered frequency doubled
// - reference sources bypass the output divider
// - format 0 off, 1 AC differential, 2 HCSL, 3 single-ended CMOS
// - CMOS true pin: tri off, low off, inverted on, true on; else strength
// - CMOS complement pin same four codes; HCSL load, zero means tri-state
// - divider divides by stored code plus one, 1 to 256
// - divider acts only on synthesizer sources
module oscp_top #(
   parameter int DIV_W = 8
) (
   input wire logic mclk_in, // 10 MHz system clock
   input wire logic sys_rst_in, // synchronous reset, high
   input wire logic [9:0] avs_address_in, // byte address
   input wire logic avs_read_in, // read request
   input wire logic avs_write_in, // write request
   input wire logic [31:0] avs_writedata_in, // write data
   input wire logic [3:0] avs_byteenable_in, // byte lanes
   output logic [31:0] avs_readdata_out, // read data
   output logic avs_waitrequest_out, // stall
   input wire logic syn1_clk_in, // first synthesizer clock
   input wire logic syn2_clk_in, // second synthesizer clock
   input wire logic ref_pri_clk_in, // primary reference
   input wire logic ref_sec_clk_in, // secondary reference
   input wire logic doubler_en_in, // reference doubler enable
   output logic diff_p_out, // differential true side
   output logic diff_n_out, // differential complement side
   output logic diff_en_out, // differential driver on
   output logic [1:0] diff_strength_out, // tail current code
   output logic [1:0] hcsl_load_out, // load code
   output logic hcsl_tri_out, // HCSL tri-stated
   output logic true_pin_out, // CMOS true pin level
   output logic true_pin_oe_n_out, // CMOS true pin enable, low drives
   output logic comp_pin_out, // CMOS complement pin level
   output logic comp_pin_oe_n_out, // CMOS complement enable, low drives
   output logic [1:0] format_out // current driver format
);
   logic [7:0] ctl_q;
   logic [DIV_W-1:0] div_q;
   logic ack_q;
   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   logic [1:0] ref_prev_q;
   logic dbl_en;
   logic pri_src, sec_src, src;
   logic bypass;
   logic div_clk;
   logic [1:0] src_sel, fmt, mode1, mode2;
   logic req, wr_ok;

   // ------------------------------------------------------------
   // register bus slave
   // ------------------------------------------------------------
   assign req = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = req & ~ack_q;
   assign wr_ok = avs_write_in & ack_q & avs_byteenable_in[0];

   // one wait cycle per request, then accept
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         ack_q <= 1'b0;
      else
         ack_q <= req & ~ack_q;
   end

   // read data prepared during the wait cycle, unmapped reads zero
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         avs_readdata_out <= '0;
      else if (avs_read_in && !ack_q)
      begin
         unique case (avs_address_in)
            oscp_pkg::OUTCTL_ADDR: avs_readdata_out <= {24'h00_0000, ctl_q};
            oscp_pkg::OUTDIV_ADDR: avs_readdata_out <= 32'(div_q);
            default: avs_readdata_out <= '0;
         endcase
      end
   end

   // control register
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         ctl_q <= oscp_pkg::OUTCTL_RST;
      else if (wr_ok && avs_address_in == oscp_pkg::OUTCTL_ADDR)
         ctl_q <= avs_writedata_in[7:0];
   end

   // divider register
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         div_q <= DIV_W'(oscp_pkg::OUTDIV_RST);
      else if (wr_ok && avs_address_in == oscp_pkg::OUTDIV_ADDR)
         div_q <= avs_writedata_in[DIV_W-1:0];
   end

   // field split
   assign src_sel = ctl_q[oscp_pkg::SRC_LSB +: oscp_pkg::FLD_W];
   assign fmt = ctl_q[oscp_pkg::FMT_LSB +: oscp_pkg::FLD_W];
   assign mode1 = ctl_q[oscp_pkg::MODE1_LSB +: oscp_pkg::FLD_W];
   assign mode2 = ctl_q[oscp_pkg::MODE2_LSB +: oscp_pkg::FLD_W];

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= {doubler_en_in, ref_sec_clk_in, ref_pri_clk_in, syn2_clk_in, syn1_clk_in};
         sync2_q <= sync1_q;
      end
   end

   assign dbl_en = sync2_q[4];

   // previous reference levels for the doubler edge detect
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         ref_prev_q <= '0;
      else
         ref_prev_q <= sync2_q[3:2];
   end

   // ------------------------------------------------------------
   // source select with doubler: a pulse on every reference edge
   // ------------------------------------------------------------
   assign pri_src = dbl_en ? (sync2_q[2] ^ ref_prev_q[0]) : sync2_q[2];
   assign sec_src = dbl_en ? (sync2_q[3] ^ ref_prev_q[1]) : sync2_q[3];

   // channel source mux
   always_comb
   begin
      unique case (oscp_pkg::oscp_src_t'(src_sel))
         oscp_pkg::OSCP_SRC_SYN1: src = sync2_q[0];
         oscp_pkg::OSCP_SRC_SYN2: src = sync2_q[1];
         oscp_pkg::OSCP_SRC_PRI: src = pri_src;
         oscp_pkg::OSCP_SRC_SEC: src = sec_src;
      endcase
   end

   assign bypass = (src_sel == oscp_pkg::OSCP_SRC_PRI) || (src_sel == oscp_pkg::OSCP_SRC_SEC);

   oscp_divider #(
      .DIV_W(DIV_W)
   ) u_div (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .clk_in(src),
      .div_in(div_q),
      .bypass_in(bypass),
      .clk_out(div_clk)
   );

   // ------------------------------------------------------------
   // output driver
   // ------------------------------------------------------------
   function automatic logic [1:0] pin_drive(input logic [1:0] mode, input logic clk);
      // returns {oe_n, level}
      unique case (mode)
         oscp_pkg::PIN_OFF_TRI: pin_drive = 2'b10;
         oscp_pkg::PIN_OFF_LOW: pin_drive = 2'b00;
         oscp_pkg::PIN_ON_INV: pin_drive = {1'b0, ~clk};
         oscp_pkg::PIN_ON_TRUE: pin_drive = {1'b0, clk};
      endcase
   endfunction

   // registered driver state per format
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         {diff_p_out, diff_n_out, diff_en_out} <= 3'b000;
         diff_strength_out <= '0;
         hcsl_load_out <= '0;
         hcsl_tri_out <= 1'b1;
         {true_pin_oe_n_out, true_pin_out} <= 2'b10;
         {comp_pin_oe_n_out, comp_pin_out} <= 2'b10;
         format_out <= '0;
      end
      else
      begin
         format_out <= fmt;
         diff_strength_out <= mode1;
         hcsl_load_out <= mode2;
         hcsl_tri_out <= (fmt != oscp_pkg::OSCP_FMT_HCSL) || (mode2 == oscp_pkg::HCSL_LOAD_TRI);
         unique case (oscp_pkg::oscp_fmt_t'(fmt))
            oscp_pkg::OSCP_FMT_OFF:
            begin
               {diff_p_out, diff_n_out, diff_en_out} <= 3'b000;
               {true_pin_oe_n_out, true_pin_out} <= 2'b10;
               {comp_pin_oe_n_out, comp_pin_out} <= 2'b10;
            end
            oscp_pkg::OSCP_FMT_ACDIFF, oscp_pkg::OSCP_FMT_HCSL:
            begin
               {diff_p_out, diff_n_out, diff_en_out} <= {div_clk, ~div_clk, 1'b1};
               {true_pin_oe_n_out, true_pin_out} <= 2'b10;
               {comp_pin_oe_n_out, comp_pin_out} <= 2'b10;
            end
            oscp_pkg::OSCP_FMT_CMOS:
            begin
               {diff_p_out, diff_n_out, diff_en_out} <= 3'b000;
               {true_pin_oe_n_out, true_pin_out} <= pin_drive(mode1, div_clk);
               {comp_pin_oe_n_out, comp_pin_out} <= pin_drive(mode2, div_clk);
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_src_syn1;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (src_sel == oscp_pkg::OSCP_SRC_SYN1) |-> (src == sync2_q[0]) && !bypass;
   endproperty
   a_src_syn1: assert property (p_src_syn1)
      else $error("code zero does not route first synthesizer");

   property p_src_dbl;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (src_sel == oscp_pkg::OSCP_SRC_SEC && dbl_en) |-> (src == (sync2_q[3] ^ ref_prev_q[1]));
   endproperty
   a_src_dbl: assert property (p_src_dbl)
      else $error("secondary reference not doubled");

   property p_bypass;
      @(posedge mclk_in) disable iff (sys_rst_in)
      src_sel[1] |-> bypass;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("reference source not bypassing divider");

   property p_fmt_out;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (!sys_rst_in && fmt == oscp_pkg::OSCP_FMT_ACDIFF)
         |=> diff_en_out && true_pin_oe_n_out && comp_pin_oe_n_out;
   endproperty
   a_fmt_out: assert property (p_fmt_out)
      else $error("differential format not driving differential pair");

   property p_true_low;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (!sys_rst_in && fmt == oscp_pkg::OSCP_FMT_CMOS && mode1 == oscp_pkg::PIN_OFF_LOW)
         |=> !true_pin_oe_n_out && !true_pin_out;
   endproperty
   a_true_low: assert property (p_true_low)
      else $error("true pin not held low");

   property p_comp_inv;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (!sys_rst_in && fmt == oscp_pkg::OSCP_FMT_CMOS && mode2 == oscp_pkg::PIN_ON_INV)
         |=> !comp_pin_oe_n_out && (comp_pin_out == !$past(div_clk));
   endproperty
   a_comp_inv: assert property (p_comp_inv)
      else $error("complement pin not inverted");

   property p_off;
      @(posedge mclk_in) disable iff (sys_rst_in)
      (!sys_rst_in && fmt == oscp_pkg::OSCP_FMT_OFF)
         |=> !diff_en_out && !diff_p_out && true_pin_oe_n_out && comp_pin_oe_n_out;
   endproperty
   a_off: assert property (p_off)
      else $error("disabled output is active");

   property p_wait;
      @(posedge mclk_in) disable iff (sys_rst_in)
      ($rose(req) && !ack_q) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
   endproperty
   a_wait: assert property (p_wait)
      else $error("request not answered after one wait cycle");

   c_cmos: cover property (@(posedge mclk_in) fmt == oscp_pkg::OSCP_FMT_CMOS && !true_pin_oe_n_out);
   c_dbl: cover property (@(posedge mclk_in) dbl_en && src_sel == oscp_pkg::OSCP_SRC_PRI);
   c_div: cover property (@(posedge mclk_in) !bypass && div_q != '0 && $rose(div_clk));
endmodule // oscp_top

/* dv/oscp_bench.sv */
module oscp_bench;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   typedef struct {logic [7:0] ctl; logic [7:0] dv; logic dbl; int sel; int per;} oscp_row_t;
   logic mclk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [9:0] adr = 10'h000;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0000_0000;
   logic [3:0] be = 4'hf;
   logic s1 = 1'b0, s2 = 1'b0, rp = 1'b0, rs = 1'b0, dbl = 1'b0;
   logic [31:0] rdat;
   logic wait_q, dp, dn, den, htri, tp, toe, cp, coe;
   logic [1:0] dstr, hload, fmt;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   int per;
   logic [31:0] q;
   // sources: periods of 4, 6, 8 and 10 clocks
   oscp_row_t rows[9] = '{
      '{8'h3f, 8'h00, 1'b0, 0, 4}, '{8'h7f, 8'h02, 1'b0, 0, 18}, '{8'hbf, 8'h05, 1'b0, 0, 8},
      '{8'hff, 8'h03, 1'b0, 0, 10}, '{8'hbf, 8'h00, 1'b1, 0, 4}, '{8'hff, 8'h00, 1'b1, 0, 5},
      '{8'h1c, 8'h01, 1'b0, 1, 8}, '{8'h2d, 8'hff, 1'b0, 1, 1024}, '{8'h0f, 8'h00, 1'b0, 0, 0}};

   always #50 mclk_in = ~mclk_in;

   // source clock generation
   always @(posedge mclk_in)
   begin
      cyc <= cyc + 1;
      s1 <= (cyc % 4) < 2;
      s2 <= (cyc % 6) < 3;
      rp <= (cyc % 8) < 4;
      rs <= (cyc % 10) < 5;
   end

   oscp_top dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
      .avs_readdata_out(rdat), .avs_waitrequest_out(wait_q), .syn1_clk_in(s1),
      .syn2_clk_in(s2), .ref_pri_clk_in(rp), .ref_sec_clk_in(rs), .doubler_en_in(dbl),
      .diff_p_out(dp), .diff_n_out(dn), .diff_en_out(den), .diff_strength_out(dstr),
      .hcsl_load_out(hload), .hcsl_tri_out(htri), .true_pin_out(tp),
      .true_pin_oe_n_out(toe), .comp_pin_out(cp), .comp_pin_oe_n_out(coe), .format_out(fmt));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one bus cycle, started right after a rising edge; the request holds until
   // the rising edge at which waitrequest samples low, then one idle edge
   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
      input logic [3:0] b, output logic [31:0] r);
      int i;
      adr <= a;
      wd <= d;
      be <= b;
      wr <= w;
      rd <= !w;
      for (i = 0; i < 20; i++)
      begin
         @(posedge mclk_in);
         if (wait_q === 1'b0)
            break;
      end
      if (i == 20)
      begin
         n_mismatch++;
         end_sim();
      end
      r = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge mclk_in);
   endtask

   // interval between the second and third rise of the watched output
   task automatic meas(input int sel, output int p);
      int n;
      int t0;
      logic prv;
      logic cur;
      n = 0;
      p = 0;
      t0 = 0;
      prv = 1'b1;
      for (int k = 0; k < 3500; k++)
      begin
         @(negedge mclk_in);
         cur = sel ? dp : tp;
         if (cur === 1'b1 && prv === 1'b0)
         begin
            n++;
            if (n == 2)
               t0 = k;
            if (n == 3)
            begin
               p = k - t0;
               break;
            end
         end
         prv = cur;
      end
   endtask

   // driver state expected from a control byte
   task automatic stat(input logic [7:0] c);
      @(negedge mclk_in);
      chk(fmt, c[5:4]);
      chk(den, c[5:4] == 2'h1 || c[5:4] == 2'h2);
      chk(htri, !(c[5:4] == 2'h2 && c[1:0] != 2'h0));
      chk(toe, !(c[5:4] == 2'h3 && c[3:2] != 2'h0));
      chk(coe, !(c[5:4] == 2'h3 && c[1:0] != 2'h0));
      chk(dstr, c[3:2]);
      chk(hload, c[1:0]);
      chk(dn, (c[5:4] == 2'h1 || c[5:4] == 2'h2) ? !dp : 1'b0);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      @(posedge mclk_in);
      // table of source, divider, doubler and format settings
      foreach (rows[i])
      begin
         dbl <= rows[i].dbl;
         bus(1'b1, oscp_pkg::OUTCTL_ADDR, {24'h0, rows[i].ctl}, 4'hf, q);
         bus(1'b1, oscp_pkg::OUTDIV_ADDR, {24'h0, rows[i].dv}, 4'hf, q);
         repeat (10) @(posedge mclk_in);
         stat(rows[i].ctl);
         meas(rows[i].sel, per);
         chk(per, rows[i].per);
         $display("row %0d done", i);
         @(posedge mclk_in);
      end
      // reset in mid-run, then register reset values
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      stat(8'h00);
      @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      @(posedge mclk_in);
      bus(1'b0, oscp_pkg::OUTCTL_ADDR, 32'h0, 4'hf, q);
      chk(q, 32'h0000_0018);
      bus(1'b0, oscp_pkg::OUTDIV_ADDR, 32'h0, 4'hf, q);
      chk(q, 32'h0000_0005);
      $display("reset test done");
      // unmapped read, masked write, upper bits read zero
      bus(1'b0, 10'h000, 32'h0, 4'hf, q);
      chk(q, 32'h0000_0000);
      bus(1'b1, oscp_pkg::OUTCTL_ADDR, 32'h0000_00ff, 4'he, q);
      bus(1'b0, oscp_pkg::OUTCTL_ADDR, 32'h0, 4'hf, q);
      chk(q, 32'h0000_0018);
      bus(1'b1, oscp_pkg::OUTDIV_ADDR, 32'hffff_ffff, 4'hf, q);
      bus(1'b0, oscp_pkg::OUTDIV_ADDR, 32'h0, 4'hf, q);
      chk(q, 32'h0000_00ff);
      $display("bus test done");
      // single-ended pin codes: low off, then inverted true against true complement
      bus(1'b1, oscp_pkg::OUTCTL_ADDR, 32'h0000_0034, 4'hf, q);
      repeat (10) @(posedge mclk_in);
      stat(8'h34);
      per = 0;
      repeat (40) @(negedge mclk_in) per += (tp !== 1'b0);
      chk(per, 0);
      @(posedge mclk_in);
      bus(1'b1, oscp_pkg::OUTCTL_ADDR, 32'h0000_003b, 4'hf, q);
      repeat (10) @(posedge mclk_in);
      stat(8'h3b);
      per = 0;
      repeat (40) @(negedge mclk_in) per += (tp === cp);
      chk(per, 0);
      @(posedge mclk_in);
      bus(1'b1, oscp_pkg::OUTCTL_ADDR, 32'h0000_0031, 4'hf, q);
      repeat (10) @(posedge mclk_in);
      stat(8'h31);
      per = 0;
      repeat (40) @(negedge mclk_in) per += (cp !== 1'b0);
      chk(per, 0);
      $display("pin mode test done");
      end_sim();
   end
endmodule // oscp_bench
